// >>> include/glcm_cfg.svh
// constants for the glitchless clock selector and fan-out
`ifndef GLCM_CFG_SVH
`define GLCM_CFG_SVH

// ----------------------------------------
// timing and size constants
// ----------------------------------------
`define GLCM_NUM_OUT 6
`define GLCM_HOLD_CYC 2'h3
`define GLCM_CNT_W 2
`define GLCM_SYNC_W 4
`define GLCM_CORE_MHZ 50
`define GLCM_SWITCH_MAX_MHZ 650
`define GLCM_FWD_MAX_MHZ 800

// ----------------------------------------
// positions inside the synchroniser vector
// ----------------------------------------
`define GLCM_BIT_CLK1 0
`define GLCM_BIT_CLK2 1
`define GLCM_BIT_SEL 2
`define GLCM_BIT_FORCE 3

`endif

// >>> include/glcm_pkg.sv
// types for the glitchless clock selector and fan-out
package glcm_pkg;

   // ----------------------------------------
   // switch-over sequencer states
   // ----------------------------------------
   typedef enum logic [1:0]
   {
      GLCM_RUN,
      GLCM_HOLD_OLD,
      GLCM_HOLD_NEW
   } glcm_state_t;

endpackage : glcm_pkg

// >>> rtl/glcm_sync.sv
// two-flop synchroniser with rising-edge detect for pin inputs
`timescale 1ns/1ps

module glcm_sync #(
   parameter int W = 4
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [W-1:0] din,
   output logic [W-1:0] lvl,
   output logic [W-1:0] rise
);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;
   logic [W-1:0] prev_q;

   // ----------------------------------------
   // synchroniser chain
   // ----------------------------------------
   // first stage feeds only the second one
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         meta_q <= '0;
         sync_q <= '0;
         prev_q <= '0;
      end
      else
      begin
         meta_q <= din;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // edge detect works on the settled stages only
   assign lvl = sync_q;
   assign rise = sync_q & ~prev_q;

endmodule : glcm_sync

// >>> rtl/glcm_top.sv
// glitchless two-source clock selector with six-pair fan-out
//
// Operation
// - A low select routes the second clock and a high select the first clock.
// - On a select change the outputs sit low for at most three cycles of the old clock.
// - Then they stay low for at most three new-clock cycles before the new clock is forwarded.
// - Switching is free of glitches for input clocks up to 650 MHz.
// - Clocks up to 800 MHz are buffered from the chosen input to the outputs.
// - The one chosen clock fans out to six true and complementary output pairs.
// - A high hold input parks every pair at once, a low one lets them toggle.
// - The hold level sets parked true outputs to its value and complements to the inverse.
// - A low sleep input pulls both output polarities high while the sequencer keeps running.
// - A rising force edge selects the input named by the select pin at once.
`timescale 1ns/1ps

`include "glcm_cfg.svh"

module glcm_top (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic ref_clk1,
   input wire logic ref_clk2,
   input wire logic source_choice,
   input wire logic forced_switch_pulse,
   input wire logic output_hold_n,
   input wire logic hold_level,
   input wire logic sleep_n,
   output logic [`GLCM_NUM_OUT-1:0] clk_out_p,
   output logic [`GLCM_NUM_OUT-1:0] clk_out_n
);

   // ----------------------------------------
   // pin synchronisation
   // ----------------------------------------
   logic [`GLCM_SYNC_W-1:0] pin_lvl;
   logic [`GLCM_SYNC_W-1:0] pin_rise;

   glcm_sync #(
      .W(`GLCM_SYNC_W)
   ) u_sync (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .din({forced_switch_pulse, source_choice, ref_clk2, ref_clk1}),
      .lvl(pin_lvl),
      .rise(pin_rise)
   );

   // picks the first clock when the select is high, else the second
   function automatic logic glcm_pick(input logic sel, input logic c1, input logic c2);
      glcm_pick = sel ? c1 : c2;
   endfunction : glcm_pick

   // ----------------------------------------
   // sequencer state
   // ----------------------------------------
   glcm_pkg::glcm_state_t state_q;
   glcm_pkg::glcm_state_t state_d;
   logic cur_sel_q;
   logic cur_sel_d;
   logic [`GLCM_CNT_W-1:0] cnt_q;
   logic [`GLCM_CNT_W-1:0] cnt_d;
   logic fwd_q;
   logic fwd_d;

   wire sel_s = pin_lvl[`GLCM_BIT_SEL];
   wire force_rise = pin_rise[`GLCM_BIT_FORCE];
   wire sel_moved = (sel_s != cur_sel_q);
   // edges and level of the clock now routed, and level of the one routed next cycle
   wire cur_rise = glcm_pick(cur_sel_q, pin_rise[`GLCM_BIT_CLK1], pin_rise[`GLCM_BIT_CLK2]);
   wire cur_lvl = glcm_pick(cur_sel_q, pin_lvl[`GLCM_BIT_CLK1], pin_lvl[`GLCM_BIT_CLK2]);
   wire last_edge = (cnt_q == `GLCM_HOLD_CYC - 2'h1);
   wire new_lvl = glcm_pick(cur_sel_d, pin_lvl[`GLCM_BIT_CLK1], pin_lvl[`GLCM_BIT_CLK2]);

   // ----------------------------------------
   // switch-over sequencing
   // ----------------------------------------
   // force edge wins over everything: old clock may be dead
   always_comb
   begin
      state_d = state_q;
      cur_sel_d = cur_sel_q;
      cnt_d = cnt_q;
      if (force_rise)
      begin
         cur_sel_d = sel_s;
         state_d = glcm_pkg::GLCM_HOLD_NEW;
         cnt_d = '0;
      end
      else
      begin
         unique case (state_q)
            glcm_pkg::GLCM_RUN:
            begin
               // leave only in a low phase so the running high pulse is not cut short;
               // a source stuck high therefore needs the force edge to switch away
               if (sel_moved && !cur_lvl)
               begin
                  state_d = glcm_pkg::GLCM_HOLD_OLD;
                  cnt_d = '0;
               end
            end
            glcm_pkg::GLCM_HOLD_OLD:
            begin
               // third old edge ends the hold, target read at that moment
               if (cur_rise && last_edge)
               begin
                  cur_sel_d = sel_s;
                  state_d = glcm_pkg::GLCM_HOLD_NEW;
                  cnt_d = '0;
               end
               else if (cur_rise)
               begin
                  cnt_d = cnt_q + 2'h1;
               end
            end
            glcm_pkg::GLCM_HOLD_NEW:
            begin
               if (sel_moved)
               begin
                  state_d = glcm_pkg::GLCM_HOLD_OLD;  // restart toward the new target
                  cnt_d = '0;
               end
               else if (cur_rise && last_edge)
               begin
                  state_d = glcm_pkg::GLCM_RUN;
               end
               else if (cur_rise)
               begin
                  cnt_d = cnt_q + 2'h1;
               end
            end
         endcase
      end
   end

   // forwarded level is low in every hold state, so no short pulse escapes
   assign fwd_d = (state_d == glcm_pkg::GLCM_RUN) & new_lvl;

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_q <= glcm_pkg::GLCM_HOLD_NEW;
         cur_sel_q <= 1'b0;
         cnt_q <= '0;
         fwd_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cur_sel_q <= cur_sel_d;
         cnt_q <= cnt_d;
         fwd_q <= fwd_d;
      end
   end

   // ----------------------------------------
   // output fan-out and asynchronous parking
   // ----------------------------------------
   // park and sleep act straight from the pins, so runts are possible on change
   wire parked = output_hold_n;
   wire true_lvl = !sleep_n ? 1'b1 : (parked ? hold_level : fwd_q);
   wire comp_lvl = !sleep_n ? 1'b1 : (parked ? ~hold_level : ~fwd_q);

   genvar gi;
   generate
      for (gi = 0; gi < `GLCM_NUM_OUT; gi = gi + 1)
      begin : g_pair
         assign clk_out_p[gi] = true_lvl;
         assign clk_out_n[gi] = comp_lvl;
      end
   endgenerate

   // ----------------------------------------
   // checks
   // ----------------------------------------
   chk_route_select: assert property (@(posedge core_clk) disable iff (sys_rst)
      (state_q == glcm_pkg::GLCM_RUN && $past(state_q) == glcm_pkg::GLCM_RUN && !$past(force_rise))
      |-> fwd_q == $past(glcm_pick(cur_sel_q, pin_lvl[0], pin_lvl[1])))
      else $error("forwarded clock is not the selected input");

   chk_sel_change_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
      (state_q == glcm_pkg::GLCM_RUN && sel_moved && !force_rise)
      |=> (state_q == glcm_pkg::GLCM_HOLD_OLD) != $past(cur_lvl) && fwd_q == $past(cur_lvl))
      else $error("select change did not enter the old-clock hold");

   chk_old_hold_end: assert property (@(posedge core_clk) disable iff (sys_rst)
      (state_q == glcm_pkg::GLCM_HOLD_OLD && cur_rise && cnt_q == 2'h2 && !force_rise)
      |=> state_q == glcm_pkg::GLCM_HOLD_NEW && cnt_q == 2'h0 && cur_sel_q == $past(sel_s))
      else $error("old-clock hold exceeded three edges");

   chk_new_hold_end: assert property (@(posedge core_clk) disable iff (sys_rst)
      (state_q == glcm_pkg::GLCM_HOLD_NEW && cur_rise && cnt_q == 2'h2 && !sel_moved
       && !force_rise) |=> state_q == glcm_pkg::GLCM_RUN)
      else $error("new-clock hold exceeded three edges");

   chk_hold_low: assert property (@(posedge core_clk) disable iff (sys_rst)
      state_q != glcm_pkg::GLCM_RUN |-> !fwd_q)
      else $error("clock leaked during a hold");

   chk_force_jump: assert property (@(posedge core_clk) disable iff (sys_rst)
      force_rise |=> state_q == glcm_pkg::GLCM_HOLD_NEW && cur_sel_q == $past(sel_s)
      && cnt_q == 2'h0)
      else $error("force edge did not take the pin choice");

   chk_park_level: assert property (@(posedge core_clk) disable iff (sys_rst)
      (output_hold_n && sleep_n) |-> clk_out_p == {`GLCM_NUM_OUT{hold_level}}
      && clk_out_n == {`GLCM_NUM_OUT{~hold_level}})
      else $error("parked outputs at wrong level");

   chk_fanout_toggle: assert property (@(posedge core_clk) disable iff (sys_rst)
      (!output_hold_n && sleep_n) |-> clk_out_p == {`GLCM_NUM_OUT{fwd_q}}
      && clk_out_n == {`GLCM_NUM_OUT{~fwd_q}})
      else $error("outputs do not follow the forwarded clock");

   chk_sleep_pull: assert property (@(posedge core_clk) disable iff (sys_rst)
      !sleep_n |-> (&clk_out_p) && (&clk_out_n))
      else $error("sleep did not pull both polarities high");

   cov_plain_switch: cover property (@(posedge core_clk) disable iff (sys_rst)
      state_q == glcm_pkg::GLCM_HOLD_OLD ##1 state_q == glcm_pkg::GLCM_HOLD_NEW);
   cov_forced_switch: cover property (@(posedge core_clk) disable iff (sys_rst)
      force_rise ##1 state_q == glcm_pkg::GLCM_HOLD_NEW);
   cov_back_to_run: cover property (@(posedge core_clk) disable iff (sys_rst)
      state_q == glcm_pkg::GLCM_HOLD_NEW ##1 state_q == glcm_pkg::GLCM_RUN);
   cov_wait_low: cover property (@(posedge core_clk) disable iff (sys_rst)
      (state_q == glcm_pkg::GLCM_RUN && sel_moved && cur_lvl) ##1 state_q == glcm_pkg::GLCM_RUN);

endmodule : glcm_top

// >>> tb/glcm_ref_src.sv
// reference clock sources for the selector bench, each able to stick
`timescale 1ns/1ps

module glcm_ref_src (
   input wire logic stuck1,
   input wire logic stuck2,
   output logic ref_clk1,
   output logic ref_clk2
);
   logic osc1 = 1'h0;
   logic osc2 = 1'h0;
   // --------------------------------
   // oscillators, 280 ns and 160 ns
   // --------------------------------
   // odd offsets keep source edges away from core clock edges
   initial
   begin
      #7;
      forever #140 osc1 = ~osc1;
   end
   initial
   begin
      #13;
      forever #80 osc2 = ~osc2;
   end
   // a missing source freezes at its last level, never idles cleanly
   always_latch
   begin
      if (!stuck1)
         ref_clk1 <= osc1;
      if (!stuck2)
         ref_clk2 <= osc2;
   end
endmodule : glcm_ref_src

// >>> tb/glitchless_clock_mux_fanout_tb_top.sv
// self-checking bench for the glitchless clock selector and fan-out
`timescale 1ns/1ps
`include "glcm_cfg.svh"

module glitchless_clock_mux_fanout_tb_top;
   logic core_clk, sys_rst, stuck1, stuck2, ref_clk1, ref_clk2;
   logic source_choice, forced_switch_pulse, output_hold_n, hold_level, sleep_n, mon_en;
   logic [`GLCM_NUM_OUT-1:0] clk_out_p, clk_out_n;
   int n_mismatch, num_checks, n, run_len, hi_len;
   glcm_ref_src u_src (.stuck1(stuck1), .stuck2(stuck2), .ref_clk1(ref_clk1),
      .ref_clk2(ref_clk2));
   glcm_top u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .ref_clk1(ref_clk1),
      .ref_clk2(ref_clk2), .source_choice(source_choice),
      .forced_switch_pulse(forced_switch_pulse), .output_hold_n(output_hold_n),
      .hold_level(hold_level), .sleep_n(sleep_n), .clk_out_p(clk_out_p),
      .clk_out_n(clk_out_n));
   // --------------------------------
   // helpers
   // --------------------------------
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : results
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   // source period in core cycles
   function automatic int per_cyc(input logic sel);
      return sel ? 14 : 8;
   endfunction : per_cyc
   // cycles until the next output rise, bounded
   task automatic wait_rise(input int lim, output int cnt);
      logic prev;
      cnt = 0;
      prev = clk_out_p[0];
      @(negedge core_clk);
      while (!(clk_out_p[0] === 1'h1 && prev === 1'h0))
      begin
         prev = clk_out_p[0];
         cnt++;
         if (cnt > lim)
         begin
            $display("[FAIL] output rise expected within %0d seen none", lim);
            n_mismatch++;
            results();
         end
         @(negedge core_clk);
      end
   endtask : wait_rise
   task automatic check_period(input logic sel);
      wait_rise(40, n);
      wait_rise(40, n);
      check("output period", n + 1, per_cyc(sel));
      check("pairs", {clk_out_p, clk_out_n}, {{6{clk_out_p[0]}}, {6{~clk_out_p[0]}}});
   endtask : check_period
   task automatic sw_check(input logic sel);
      logic old;
      logic [`GLCM_NUM_OUT-1:0] acc;
      old = source_choice;
      source_choice = sel;
      if (old !== sel)
      begin
         acc = '0;
         // the old clock may finish its high phase before the hold starts
         repeat (per_cyc(old) / 2 + 5) @(negedge core_clk);
         repeat (10)
         begin
            acc = acc | clk_out_p;
            @(negedge core_clk);
         end
         check("low in switch", acc, 0);
         wait_rise(3 * (per_cyc(old) + per_cyc(sel)) - 7, n);
      end
      check_period(sel);
   endtask : sw_check
   task automatic park(input logic hl);
      int k;
      // park while the output already shows the parked level, so no runt is cut
      k = 0;
      while (clk_out_p[0] !== hl && k <= 40)
      begin
         k++;
         @(negedge core_clk);
      end
      if (k > 40)
      begin
         $display("[FAIL] park moment expected within 40 seen none");
         n_mismatch++;
         results();
      end
      hold_level = hl;
      output_hold_n = 1'h1;
      #1;
      check("parked p", clk_out_p, {6{hl}});
      check("parked n", clk_out_n, {6{~hl}});
   endtask : park
   // --------------------------------
   // clock, low- and high-pulse monitor, watchdog
   // --------------------------------
   initial
   begin
      core_clk = 1'h0;
      forever #10 core_clk = ~core_clk;
   end
   // a short low or high run in a running clock is a glitch; judged only at a level change
   always @(negedge core_clk)
   begin
      if (!mon_en)
      begin
         run_len = 100;
         hi_len = 100;
      end
      else if (clk_out_p[0] === 1'h1 && run_len > 0 && run_len < 4)
         check("low pulse width", run_len, 4);
      else if (clk_out_p[0] === 1'h0 && hi_len > 0 && hi_len < 4)
         check("high pulse width", hi_len, 4);
      run_len = (clk_out_p[0] === 1'h0) ? run_len + 1 : 0;
      hi_len = (clk_out_p[0] === 1'h1) ? hi_len + 1 : 0;
   end
   initial
   begin
      #1000000;
      $display("[FAIL] run time expected bounded seen overrun");
      n_mismatch++;
      results();
   end
   // --------------------------------
   // main sequence
   // --------------------------------
   initial
   begin
      {sys_rst, stuck1, stuck2, source_choice, mon_en} = 5'h10;
      forced_switch_pulse = 1'h0;
      {output_hold_n, hold_level, sleep_n} = 3'h1;
      n_mismatch = 0;
      num_checks = 0;
      void'($urandom(32'h32C9));
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      sys_rst = 1'h0;
      mon_en = 1'h1;
      check_period(1'h0);
      $display("test reset done");
      sw_check(1'h1);
      sw_check(1'h0);
      for (int i = 0; i < 8; i++)
         sw_check(1'($urandom % 2));
      $display("test switching done");
      sw_check(1'h1);
      mon_en = 1'h0;
      stuck1 = 1'h1;
      source_choice = 1'h0;
      repeat (2) @(negedge core_clk);
      forced_switch_pulse = 1'h1;
      wait_rise(3 * per_cyc(1'h0) + 8, n);
      forced_switch_pulse = 1'h0;
      check_period(1'h0);
      stuck1 = 1'h0;
      $display("test forced switch done");
      for (int i = 0; i < 6; i++)
      begin
         @(negedge core_clk);
         park(i < 2 ? 1'(i) : 1'($urandom % 2));
         @(negedge core_clk);
         output_hold_n = 1'h0;
         check_period(source_choice);
      end
      $display("test parking done");
      park(1'($urandom % 2));
      sleep_n = 1'h0;
      #1;
      check("sleep p", clk_out_p, 6'h3F);
      check("sleep n", clk_out_n, 6'h3F);
      @(negedge core_clk);
      sleep_n = 1'h1;
      repeat (10) @(negedge core_clk);
      check("wake parked", clk_out_p, {6{hold_level}});
      output_hold_n = 1'h0;
      check_period(source_choice);
      $display("test sleep done");
      results();
   end
endmodule : glitchless_clock_mux_fanout_tb_top
